// ---- shared/pass_qualifier_map.svh ----
// Register map, field positions and timing counts of the port pass qualifier.
// Assumes one 8-bit control register reached at its documented offset.
// Summary of operation
// - Freeze drops pass until new image, threshold
// - Line-count change drops pass until threshold
// - Line-size change drops pass until threshold
// - Parity mode zero: pass low per error
// - Parity mode one: pass cleared until threshold
// - Watchdog drops pass without frame end
// - Watchdog ignored when threshold is zero
// - Threshold zero: pass on receiver lock
// - Nonzero threshold: pass after that many frames
// - Discard enable drops packets while unqualified
`ifndef PASS_QUALIFIER_MAP_SVH
`define PASS_QUALIFIER_MAP_SVH
`define PQ_CTL_ADDR 8'h7D
`define PQ_CTL_RESET 8'h00
`define PQ_BIT_DISCARD 7
`define PQ_BIT_FREEZE 6
`define PQ_BIT_LINE_CNT 5
`define PQ_BIT_LINE_SIZE 4
`define PQ_BIT_PARITY 3
`define PQ_BIT_WDOG_OFF 2
`define PQ_THR_HI 1
`define PQ_THR_LO 0
`define PQ_THR_ZERO 2'h0
`define PQ_WDOG_FRAMES 2
`define PQ_RDATA_NONE 8'h00
`endif

// ---- shared/pass_qualifier_pkg.sv ----
// Types shared by the port pass qualifier and its frame-end watchdog.
// Assumes the map header is compiled alongside.
package pass_qualifier_pkg;
    typedef enum logic [1:0] {ST_UNLOCKED, ST_COUNTING, ST_PASS} pass_state_t;
    typedef logic [1:0] threshold_t;
endpackage : pass_qualifier_pkg

// ---- shared/watchdog_if.sv ----
// Link between the qualifier and its frame-end watchdog.
// Assumes both ends run on the device clock.
interface watchdog_if;
    logic frame_start;
    logic frame_end;
    logic arm;
    logic expire;
    modport timer (input frame_start, input frame_end, input arm, output expire);
    modport ctl (output frame_start, output frame_end, output arm, input expire);
endinterface : watchdog_if

// ---- verilog/frame_end_watchdog.sv ----
// Measures the frame period and flags a missing frame end.
// Assumes frame start and valid frame end arrive as one-cycle pulses.
`include "pass_qualifier_map.svh"
module frame_end_watchdog #(
    parameter int CNT_W = 24
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    watchdog_if.timer wd
);
    import pass_qualifier_pkg::*;
    logic [CNT_W-1:0] period_run;
    logic [CNT_W-1:0] period;
    logic [CNT_W-1:0] since;
    logic seen_start;
    logic period_ok;
    wire [CNT_W-1:0] limit = CNT_W'(period * `PQ_WDOG_FRAMES);
    wire run_full = &period_run;
    wire since_full = &since;

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            period_run <= '0;
            period <= '0;
            since <= '0;
            seen_start <= 1'b0;
            period_ok <= 1'b0;
            wd.expire <= 1'b0;
        end else if (i_ce) begin
            period_run <= wd.frame_start ? '0 : (run_full ? period_run : period_run + 1'b1);
            if (wd.frame_start) begin
                period <= period_run;
                seen_start <= 1'b1;
                period_ok <= seen_start;
            end
            since <= (wd.frame_end || !wd.arm) ? '0 : (since_full ? since : since + 1'b1);
            // Equality gives a single pulse per missed window
            wd.expire <= wd.arm && period_ok && !wd.frame_end && since == limit;
        end
    end
endmodule : frame_end_watchdog

// ---- verilog/rx_port_pass_qualifier.sv ----
// Pass qualification and packet gating for one receive port.
// Assumes event inputs are one-cycle pulses synchronous to i_sys_clk.
`include "pass_qualifier_map.svh"
module rx_port_pass_qualifier #(
    parameter int DATA_W = 8,
    parameter int WDOG_CNT_W = 24
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    input wire logic i_reg_wr,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    output logic [7:0] o_reg_rdata,
    input wire logic i_rx_lock,
    input wire logic i_frame_start,
    input wire logic i_frame_end_valid,
    input wire logic i_freeze_det,
    input wire logic i_new_image,
    input wire logic i_line_count_chg,
    input wire logic i_line_size_chg,
    input wire logic i_parity_err,
    input wire logic i_pkt_valid,
    input wire logic [DATA_W-1:0] i_pkt_data,
    output logic o_pkt_valid,
    output logic [DATA_W-1:0] o_pkt_data,
    output logic o_pass,
    output pass_qualifier_pkg::pass_state_t o_state
);
    import pass_qualifier_pkg::*;

    logic [7:0] port_qualify_control;
    pass_state_t state;
    pass_state_t next_state;
    threshold_t frame_cnt;
    threshold_t next_frame_cnt;
    logic frozen_wait;
    logic next_frozen_wait;

    watchdog_if wd_link ();

    function automatic logic reached(input threshold_t cnt, input threshold_t thr);
        reached = (threshold_t'(cnt + 1'b1) == thr);
    endfunction : reached

    // Control field decode
    wire discard_en = port_qualify_control[`PQ_BIT_DISCARD];
    wire freeze_en = port_qualify_control[`PQ_BIT_FREEZE];
    wire line_count_qualify_en = port_qualify_control[`PQ_BIT_LINE_CNT];
    wire line_size_en = port_qualify_control[`PQ_BIT_LINE_SIZE];
    wire parity_sticky = port_qualify_control[`PQ_BIT_PARITY];
    wire frame_end_watchdog_off = port_qualify_control[`PQ_BIT_WDOG_OFF];
    wire threshold_t pass_threshold = port_qualify_control[`PQ_THR_HI:`PQ_THR_LO];
    wire thr_zero = (pass_threshold == `PQ_THR_ZERO);
    wire ctl_hit = (i_reg_addr == `PQ_CTL_ADDR);

    // Drop sources
    wire drop_freeze = freeze_en && i_freeze_det;
    wire drop_lines = line_count_qualify_en && i_line_count_chg;
    wire drop_size = line_size_en && i_line_size_chg;
    wire drop_parity = parity_sticky && i_parity_err;
    wire blip_parity = !parity_sticky && i_parity_err;
    // No watchdog drop with a zero threshold
    wire drop_wdog = wd_link.expire && !frame_end_watchdog_off && !thr_zero;
    wire drop_any = drop_freeze || drop_lines || drop_size || drop_parity || drop_wdog;
    wire gate_pkt = discard_en && !o_pass;

    assign wd_link.frame_start = i_frame_start;
    assign wd_link.frame_end = i_frame_end_valid;
    assign wd_link.arm = (state == ST_PASS);

    frame_end_watchdog #(
        .CNT_W(WDOG_CNT_W)
    ) u_watchdog (
        .i_sys_clk(i_sys_clk),
        .i_rst_b(i_rst_b),
        .i_ce(i_ce),
        .wd(wd_link)
    );

    always_comb begin
        next_state = state;
        next_frame_cnt = frame_cnt;
        next_frozen_wait = frozen_wait;
        if (drop_freeze) begin
            next_frozen_wait = 1'b1;
        end else if (i_new_image) begin
            next_frozen_wait = 1'b0;
        end
        case (state)
            ST_UNLOCKED: begin
                next_frame_cnt = '0;
                if (i_rx_lock) begin
                    next_state = ST_COUNTING;
                    // Zero threshold passes on lock alone
                    if (thr_zero && !drop_any && !next_frozen_wait) begin
                        next_state = ST_PASS;
                    end
                end
            end
            ST_COUNTING: begin
                if (drop_any) begin
                    next_frame_cnt = '0;
                end else if (!next_frozen_wait) begin
                    if (thr_zero) begin
                        next_state = ST_PASS;
                    end else if (i_frame_end_valid) begin
                        next_frame_cnt = threshold_t'(frame_cnt + 1'b1);
                        if (reached(frame_cnt, pass_threshold)) begin
                            next_state = ST_PASS;
                        end
                    end
                end
            end
            ST_PASS: begin
                if (drop_any) begin
                    next_state = ST_COUNTING;
                    next_frame_cnt = '0;
                end
            end
            default: begin
                next_state = ST_UNLOCKED;
            end
        endcase
        if (!i_rx_lock) begin
            next_state = ST_UNLOCKED;
            next_frame_cnt = '0;
            next_frozen_wait = 1'b0;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            port_qualify_control <= `PQ_CTL_RESET;
            o_reg_rdata <= `PQ_RDATA_NONE;
        end else if (i_ce) begin
            if (i_reg_wr && ctl_hit) begin
                port_qualify_control <= i_reg_wdata;
            end
            o_reg_rdata <= ctl_hit ? port_qualify_control : `PQ_RDATA_NONE;
        end
    end

    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state <= ST_UNLOCKED;
            frame_cnt <= '0;
            frozen_wait <= 1'b0;
            o_pass <= 1'b0;
            o_state <= ST_UNLOCKED;
        end else if (i_ce) begin
            state <= next_state;
            frame_cnt <= next_frame_cnt;
            frozen_wait <= next_frozen_wait;
            // Error blip masks pass for that cycle only
            o_pass <= (next_state == ST_PASS) && !blip_parity;
            o_state <= next_state;
        end
    end

    // Registered gating costs one cycle of packet latency
    always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_pkt_valid <= 1'b0;
            o_pkt_data <= '0;
        end else if (i_ce) begin
            o_pkt_valid <= i_pkt_valid && !gate_pkt;
            o_pkt_data <= i_pkt_data;
        end
    end

    sequence s_lock_quiet;
        i_ce && i_rx_lock && !drop_any && !i_parity_err && !next_frozen_wait;
    endsequence

    sequence s_last_frame;
        i_ce && state == ST_COUNTING && i_frame_end_valid && !thr_zero
            && reached(frame_cnt, pass_threshold);
    endsequence

    thr_zero_lock_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_lock_quiet and (thr_zero && state != ST_PASS) |=> o_pass && state == ST_PASS)
        else $error("pass not raised on lock with zero threshold");

    thr_count_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        s_lock_quiet and s_last_frame |=> o_pass)
        else $error("pass not raised at frame threshold");

    no_early_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && state == ST_COUNTING && !thr_zero && !i_frame_end_valid |=> !o_pass)
        else $error("pass raised without a valid frame");

    // Lock loss in the same cycle legally clears the freeze wait
    freeze_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && i_rx_lock && drop_freeze |=> !o_pass && frozen_wait)
        else $error("freeze did not drop pass");

    line_change_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && (drop_lines || drop_size) |=> !o_pass && frame_cnt == '0)
        else $error("line change did not drop pass");

    parity_blip_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && blip_parity && state == ST_PASS && !drop_any && i_rx_lock
            |=> !o_pass && state == ST_PASS)
        else $error("parity blip mishandled");

    parity_hold_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && drop_parity |=> !o_pass && state != ST_PASS)
        else $error("parity error did not clear pass");

    wdog_drop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && wd_link.expire && !frame_end_watchdog_off && !thr_zero |=> !o_pass)
        else $error("watchdog expiry did not drop pass");

    // Expiry stays out of the antecedent so a broken zero-threshold mask trips this
    wdog_ignored_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && i_rx_lock && thr_zero && state == ST_PASS && !i_parity_err && !drop_freeze
            && !drop_lines && !drop_size |=> o_pass)
        else $error("watchdog acted with zero threshold");

    lock_loss_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && !i_rx_lock |=> !o_pass && frame_cnt == '0 && state == ST_UNLOCKED)
        else $error("lock loss did not reset qualification");

    discard_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
        i_ce && i_pkt_valid |=> o_pkt_valid == !$past(gate_pkt))
        else $error("packet gating wrong");
endmodule : rx_port_pass_qualifier

// ---- testbench/video_source_model.sv ----
// Far end of the receive link: emits frame start and valid frame end pulses.
// Assumes the bench starts, stops and stalls it; outputs change after the falling edge.
module video_source_model #(
    parameter int PERIOD = 20
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_b,
    input wire logic i_run,
    input wire logic i_hold_end,
    output logic o_frame_start,
    output logic o_frame_end_valid
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt;
    always @(negedge i_sys_clk or negedge i_rst_b) begin
        if (!i_rst_b || !i_run) begin
            cnt <= 0;
            o_frame_start <= 1'b0;
            o_frame_end_valid <= 1'b0;
        end else begin
            cnt <= (cnt == PERIOD - 1) ? 0 : cnt + 1;
            o_frame_start <= (cnt == 0);
            // Held end models a link that stops closing frames
            o_frame_end_valid <= (cnt == PERIOD - 4) && !i_hold_end;
        end
    end
endmodule : video_source_model

// ---- testbench/rx_port_pass_qualifier_bench.sv ----
// Self-checking bench of the receive port pass qualifier.
// Assumes the map header and package are compiled first.
`include "pass_qualifier_map.svh"
module rx_port_pass_qualifier_bench;
    timeunit 1ns;
    timeprecision 1ps;
    import pass_qualifier_pkg::*;
    logic clk = 1'b0, rst_b = 1'b0, wr = 1'b0, lock = 1'b0, run = 1'b0, hold = 1'b0, ce = 1'b1;
    logic pv = 1'b0, opv, pass, fs, fe, p;
    logic [4:0] ev = 5'h00;
    logic [7:0] addr = 8'h00, wdata = 8'h00, pd = 8'h00, rdata, opd, r, ctl;
    pass_state_t st;
    int mismatches = 0, cmp_count = 0, cycles = 0, n, k;
    always #5 clk = ~clk;
    video_source_model src_u (.i_sys_clk(clk), .i_rst_b(rst_b), .i_run(run),
        .i_hold_end(hold), .o_frame_start(fs), .o_frame_end_valid(fe));
    rx_port_pass_qualifier #(.DATA_W(8), .WDOG_CNT_W(24)) dut_u (.i_sys_clk(clk),
        .i_rst_b(rst_b), .i_ce(ce), .i_reg_wr(wr), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .o_reg_rdata(rdata), .i_rx_lock(lock), .i_frame_start(fs),
        .i_frame_end_valid(fe), .i_freeze_det(ev[0]), .i_new_image(ev[4]),
        .i_line_count_chg(ev[1]), .i_line_size_chg(ev[2]), .i_parity_err(ev[3]),
        .i_pkt_valid(pv), .i_pkt_data(pd), .o_pkt_valid(opv), .o_pkt_data(opd),
        .o_pass(pass), .o_state(st));
    task automatic print_verdict();
        if (mismatches == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // Ceiling well above the fewer than one thousand cycles the sequence needs
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            mismatches++;
            print_verdict();
        end
    end
    task automatic check(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1) begin
            mismatches++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask : check
    task automatic tick(input int cnt);
        repeat (cnt) @(negedge clk);
    endtask : tick
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        addr = a;
        wdata = d;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        // Idle edge so a following write never re-raises the strobe at once
        tick(1);
    endtask : wr_reg
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        addr = a;
        tick(1);
        d = rdata;
    endtask : rd_reg
    task automatic pulse(input int i);
        ev[i] = 1'b1;
        tick(1);
        ev[i] = 1'b0;
    endtask : pulse
    task automatic wait_pass(input logic lvl, input int lim);
        int j = 0;
        while (pass !== lvl && j < lim) begin
            tick(1);
            j++;
        end
    endtask : wait_pass
    function automatic logic fwd(input logic disc, input logic ps, input logic v);
        return v && !(disc && !ps);
    endfunction : fwd
    initial begin
        void'($urandom(32'hE822));
        tick(4);
        rst_b = 1'b1;
        rd_reg(`PQ_CTL_ADDR, r);
        check(r === `PQ_CTL_RESET && pass === 1'b0, "reset state");
        lock = 1'b1;
        wait_pass(1'b1, 4);
        check(pass === 1'b1 && st === ST_PASS, "pass on lock");
        for (int i = 0; i < 24; i++) begin
            ctl = {i[0], 7'h00};
            wr_reg(`PQ_CTL_ADDR, ctl);
            wr_reg(8'h7C, 8'($urandom));
            rd_reg(`PQ_CTL_ADDR, r);
            check(r === ctl, "control readback");
            lock = i[1];
            pv = 1'($urandom);
            pd = 8'($urandom);
            p = pass;
            tick(1);
            check(opv === fwd(ctl[7], p, pv), "packet gating");
            check(!pv || opd === pd, "packet data");
            pv = 1'b0;
        end
        for (int t = 1; t < 4; t++) begin
            lock = 1'b0;
            run = 1'b0;
            wr_reg(`PQ_CTL_ADDR, 8'(t));
            tick(2);
            lock = 1'b1;
            run = 1'b1;
            n = 0;
            k = 0;
            while (pass !== 1'b1 && k < 200) begin
                @(posedge clk);
                n += int'(fe);
                @(negedge clk);
                k++;
            end
            check(pass === 1'b1 && n == t, "frames before pass");
            lock = 1'b0;
            tick(2);
            check(pass === 1'b0 && st === ST_UNLOCKED, "lock loss");
        end
        wr_reg(`PQ_CTL_ADDR, 8'h01);
        lock = 1'b1;
        wait_pass(1'b1, 60);
        for (int b = 0; b < 4; b++) begin
            pulse(b);
            check(pass === (b != 3) && st === ST_PASS, "event with check off");
            tick(1);
            check(pass === 1'b1, "pass kept");
            wr_reg(`PQ_CTL_ADDR, 8'h01 | (8'h40 >> b));
            pulse(b);
            check(pass === 1'b0 && st === ST_COUNTING, "event drop");
            if (b == 0) begin
                tick(30);
                check(pass === 1'b0, "frozen wait");
                pulse(4);
            end
            wait_pass(1'b1, 60);
            check(pass === 1'b1, "pass regained");
            wr_reg(`PQ_CTL_ADDR, 8'h01);
        end
        hold = 1'b1;
        wait_pass(1'b0, 80);
        check(pass === 1'b0 && st === ST_COUNTING, "watchdog drop");
        hold = 1'b0;
        wait_pass(1'b1, 60);
        for (int m = 0; m < 2; m++) begin
            // Off bit with threshold 1, then threshold 0 with watchdog on
            wr_reg(`PQ_CTL_ADDR, m == 0 ? 8'h05 : 8'h00);
            // Let a frame end restart the window so the watchdog really expires
            tick(25);
            hold = 1'b1;
            tick(100);
            check(pass === 1'b1, "watchdog inert");
            hold = 1'b0;
        end
        // Low enable must freeze pass across a lock loss
        ce = 1'b0;
        lock = 1'b0;
        tick(3);
        check(pass === 1'b1 && st === ST_PASS, "enable freeze");
        ce = 1'b1;
        tick(1);
        check(pass === 1'b0 && st === ST_UNLOCKED, "lock loss after enable");
        rst_b = 1'b0;
        tick(2);
        rst_b = 1'b1;
        rd_reg(`PQ_CTL_ADDR, r);
        check(r === `PQ_CTL_RESET && pass === 1'b0 && st === ST_UNLOCKED, "mid-run reset");
        print_verdict();
    end
endmodule : rx_port_pass_qualifier_bench
